// >>> cts_consts.svh
// register offsets, field positions, reset values for the touch scan status block
`ifndef CTS_CONSTS_SVH
`define CTS_CONSTS_SVH
`define CTS_OFF_CTRL 12'h000
`define CTS_OFF_STATUS 12'h004
`define CTS_OFF_IRQ_EN 12'h008
`define CTS_OFF_COUNT 12'h00c
`define CTS_CTRL_SCAN_EN 0
`define CTS_CTRL_CONT 1
`define CTS_CTRL_DMA_EN 2
`define CTS_CTRL_LOWPWR 3
`define CTS_ST_DONE 0
`define CTS_ST_RANGE 1
`define CTS_ST_DMA_BUSY 2
`define CTS_CTRL_RESET 4'h0
`define CTS_IRQ_EN_RESET 2'h0
`define CTS_SCAN_NS 1000
`define CTS_SCAN_CYCLES ((`CTS_SCAN_NS * 40 + 999) / 1000)
`define CTS_AXI_OKAY 2'b00
`define CTS_AXI_SLVERR 2'b10
`endif

// >>> cts_pkg.sv
// types shared by the touch scan status block
package cts_pkg;
    typedef enum logic [1:0] {
        CTS_IDLE,
        CTS_SCANNING,
        CTS_WAIT_CLEAR
    } cts_scan_state_e;
    typedef logic [31:0] cts_word_t;
endpackage

// >>> cts_scan_if.sv
// interface carrying scan events between the register slave and the sequencer
`timescale 1ns/1ps
interface cts_scan_if;
    logic scan_en;
    logic cont;
    logic done_flag;
    logic scan_done;
    logic [15:0] count;
    modport ctrl (output scan_en, output cont, output done_flag, input scan_done, input count);
    modport seq (input scan_en, input cont, input done_flag, output scan_done, output count);
endinterface

// >>> cts_scan_seq.sv
// scan sequencer: times each electrode scan and stalls until the done flag clears
`timescale 1ns/1ps
`include "cts_consts.svh"
module cts_scan_seq (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // electrode result
    input wire logic [15:0] sense_count_i,
    // link to control
    cts_scan_if.seq sif
);
    import cts_pkg::*;
    cts_scan_state_e state_reg, state_next;
    logic [7:0] tmr_reg, tmr_next;
    logic [15:0] cnt_reg, cnt_next;
    logic done_next;
    // one-cycle completion pulse, registered so the flag sets from a flip-flop
    logic done_pulse_reg;

    // next-state logic; a new scan only starts once the done flag is clear
    always_comb begin
        state_next = state_reg;
        tmr_next = tmr_reg;
        cnt_next = cnt_reg;
        done_next = 1'b0;
        unique case (state_reg)
            CTS_IDLE: begin
                if (sif.scan_en && !sif.done_flag) begin
                    state_next = CTS_SCANNING;
                    tmr_next = 8'(`CTS_SCAN_CYCLES - 1);
                end
            end
            CTS_SCANNING: begin
                if (tmr_reg == 8'h00) begin
                    cnt_next = sense_count_i;
                    done_next = 1'b1;
                    state_next = CTS_WAIT_CLEAR;
                end else begin
                    tmr_next = tmr_reg - 8'h01;
                end
            end
            CTS_WAIT_CLEAR: begin
                // no self clear even in continuous mode; stall here instead
                if (!sif.done_flag && !done_pulse_reg) begin
                    state_next = sif.cont ? CTS_IDLE : CTS_IDLE;
                end
            end
        endcase
    end

    // registers
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg <= CTS_IDLE;
            tmr_reg <= 8'h00;
            cnt_reg <= 16'h0000;
            done_pulse_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            tmr_reg <= tmr_next;
            cnt_reg <= cnt_next;
            done_pulse_reg <= done_next;
        end
    end

    assign sif.scan_done = done_pulse_reg;
    assign sif.count = cnt_reg;
endmodule

// >>> cts_top.sv
// touch scan status control: axi4-lite registers, done flag, irq, dma clear
//
// Contract
// - scan completion sets the done flag; hardware never clears it itself.
// - continuous scanning waits on the done flag; no autonomous range interrupt.
// - done flag readable for polling; enabled done interrupt raised on completion.
// - dma acknowledge clears the done flag in run mode, not low power.
`timescale 1ns/1ps
`include "cts_consts.svh"
module cts_top (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // axi4-lite write address
    input wire logic [11:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    // axi4-lite read
    input wire logic [11:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output cts_pkg::cts_word_t s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    // sensing front end (pins)
    input wire logic [15:0] sense_count_i,
    input wire logic out_of_range_i,
    // dma
    output logic dma_req_o,
    input wire logic dma_ack_i,
    // interrupt
    output logic irq_o
);
    import cts_pkg::*;

    cts_scan_if sif ();

    // pin synchronisers; first stage feeds only the second
    logic [16:0] pin_s1_reg, pin_s2_reg;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_s1_reg <= 17'h00000;
            pin_s2_reg <= 17'h00000;
        end else begin
            pin_s1_reg <= {out_of_range_i, sense_count_i};
            pin_s2_reg <= pin_s1_reg;
        end
    end

    cts_scan_seq u_seq (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .sense_count_i(pin_s2_reg[15:0]),
        .sif(sif)
    );

    // state
    logic [3:0] ctrl_reg, ctrl_next;
    logic [1:0] stat_reg, stat_next;
    logic [1:0] irq_en_reg, irq_en_next;
    logic aw_got_reg, aw_got_next;
    logic w_got_reg, w_got_next;
    logic [11:0] awaddr_reg, awaddr_next;
    cts_word_t wdata_reg, wdata_next;
    logic [3:0] wstrb_reg, wstrb_next;
    logic bvalid_reg, bvalid_next;
    logic [1:0] bresp_reg, bresp_next;
    logic rvalid_reg, rvalid_next;
    cts_word_t rdata_reg, rdata_next;
    logic [1:0] rresp_reg, rresp_next;
    logic dma_req_reg, dma_req_next;

    logic wr_fire, lowpwr, range_evt;
    logic sw_clr_done, sw_clr_range, dma_clr;

    assign lowpwr = ctrl_reg[`CTS_CTRL_LOWPWR];
    // the range flag only latches with a completed scan, so continuous
    // scanning cannot raise it while the done flag is still set
    assign range_evt = sif.scan_done & pin_s2_reg[16];
    assign wr_fire = aw_got_reg & w_got_reg & ~bvalid_reg;
    assign sw_clr_done = wr_fire && awaddr_reg == `CTS_OFF_STATUS && wstrb_reg[0]
        && wdata_reg[`CTS_ST_DONE];
    assign sw_clr_range = wr_fire && awaddr_reg == `CTS_OFF_STATUS && wstrb_reg[0]
        && wdata_reg[`CTS_ST_RANGE];
    // dma clearing is gated off in low power mode
    assign dma_clr = dma_req_reg & dma_ack_i & ~lowpwr;

    // write channel and register updates
    always_comb begin
        aw_got_next = aw_got_reg;
        w_got_next = w_got_reg;
        awaddr_next = awaddr_reg;
        wdata_next = wdata_reg;
        wstrb_next = wstrb_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        ctrl_next = ctrl_reg;
        irq_en_next = irq_en_reg;
        stat_next = stat_reg;
        dma_req_next = dma_req_reg;
        if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw_got_next = 1'b1;
            awaddr_next = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_got_next = 1'b1;
            wdata_next = s_axi_wdata_i;
            wstrb_next = s_axi_wstrb_i;
        end
        if (wr_fire) begin
            aw_got_next = 1'b0;
            w_got_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = `CTS_AXI_OKAY;
            unique case (awaddr_reg)
                `CTS_OFF_CTRL: if (wstrb_reg[0]) ctrl_next = wdata_reg[3:0];
                `CTS_OFF_STATUS: ;
                `CTS_OFF_IRQ_EN: if (wstrb_reg[0]) irq_en_next = wdata_reg[1:0];
                `CTS_OFF_COUNT: ;
                default: bresp_next = `CTS_AXI_SLVERR;
            endcase
        end else if (bvalid_reg && s_axi_bready_i) begin
            bvalid_next = 1'b0;
        end
        // clears first, so a same-cycle completion wins
        if (sw_clr_done || dma_clr) stat_next[`CTS_ST_DONE] = 1'b0;
        if (sw_clr_range) stat_next[`CTS_ST_RANGE] = 1'b0;
        if (sif.scan_done) stat_next[`CTS_ST_DONE] = 1'b1;
        if (range_evt) stat_next[`CTS_ST_RANGE] = 1'b1;
        // dma request per completed scan, dropped when acknowledged
        if (dma_ack_i || lowpwr || !ctrl_reg[`CTS_CTRL_DMA_EN]) dma_req_next = 1'b0;
        if (sif.scan_done && ctrl_reg[`CTS_CTRL_DMA_EN] && !lowpwr) dma_req_next = 1'b1;
    end

    // read channel
    always_comb begin
        rvalid_next = rvalid_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        if (s_axi_arvalid_i && s_axi_arready_o) begin
            rvalid_next = 1'b1;
            rresp_next = `CTS_AXI_OKAY;
            rdata_next = 32'h00000000;
            unique case (s_axi_araddr_i)
                `CTS_OFF_CTRL: rdata_next = {28'h0000000, ctrl_reg};
                `CTS_OFF_STATUS: rdata_next = {29'h00000000, dma_req_reg, stat_reg};
                `CTS_OFF_IRQ_EN: rdata_next = {30'h00000000, irq_en_reg};
                `CTS_OFF_COUNT: rdata_next = {16'h0000, sif.count};
                default: rresp_next = `CTS_AXI_SLVERR;
            endcase
        end else if (rvalid_reg && s_axi_rready_i) begin
            rvalid_next = 1'b0;
        end
    end

    // registers
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            awaddr_reg <= 12'h000;
            wdata_reg <= 32'h00000000;
            wstrb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= 2'h0;
            ctrl_reg <= `CTS_CTRL_RESET;
            irq_en_reg <= `CTS_IRQ_EN_RESET;
            stat_reg <= 2'h0;
            dma_req_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
            rresp_reg <= 2'h0;
        end else begin
            aw_got_reg <= aw_got_next;
            w_got_reg <= w_got_next;
            awaddr_reg <= awaddr_next;
            wdata_reg <= wdata_next;
            wstrb_reg <= wstrb_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            ctrl_reg <= ctrl_next;
            irq_en_reg <= irq_en_next;
            stat_reg <= stat_next;
            dma_req_reg <= dma_req_next;
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
        end
    end

    // continuous mode rescans only after the flag clears: no self-clear
    assign sif.scan_en = ctrl_reg[`CTS_CTRL_SCAN_EN];
    assign sif.cont = ctrl_reg[`CTS_CTRL_CONT];
    assign sif.done_flag = stat_reg[`CTS_ST_DONE];

    assign s_axi_awready_o = ~aw_got_reg & ~bvalid_reg;
    assign s_axi_wready_o = ~w_got_reg & ~bvalid_reg;
    assign s_axi_bvalid_o = bvalid_reg;
    assign s_axi_bresp_o = bresp_reg;
    assign s_axi_arready_o = ~rvalid_reg;
    assign s_axi_rvalid_o = rvalid_reg;
    assign s_axi_rdata_o = rdata_reg;
    assign s_axi_rresp_o = rresp_reg;
    assign dma_req_o = dma_req_reg;
    // level interrupt from masked sticky flags
    assign irq_o = |(stat_reg & irq_en_reg);
endmodule

// >>> cts_top_asserts.sv
// port-level assertions for the touch scan status block
`timescale 1ns/1ps
`include "cts_consts.svh"
module cts_top_asserts (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // bus handshakes
    input wire logic s_axi_awready_o,
    input wire logic s_axi_wready_o,
    input wire logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic s_axi_arvalid_i,
    input wire logic s_axi_arready_o,
    input wire cts_pkg::cts_word_t s_axi_rdata_o,
    input wire logic [1:0] s_axi_rresp_o,
    input wire logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    // dma and interrupt
    input wire logic dma_req_o,
    input wire logic dma_ack_i,
    input wire logic irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    chk_b_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o)
        else $error("write response dropped early");
    chk_r_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i
        |=> s_axi_rvalid_o && $stable(s_axi_rdata_o)) else $error("read data not held");
    chk_w_refuse: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
        else $error("write accepted during response");
    chk_ar_refuse: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
        else $error("read accepted during response");
    chk_r_latency: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
        else $error("read answer late");
    chk_err_zero: assert property (s_axi_rvalid_o && s_axi_rresp_o == `CTS_AXI_SLVERR
        |-> s_axi_rdata_o == 32'h0) else $error("error read returned data");
    // the done flag is sticky, so the interrupt only falls after a write or a dma clear
    chk_irq_sticky: assert property ($fell(irq_o) |-> $rose(s_axi_bvalid_o)
        || $past(dma_ack_i) || $past(dma_ack_i, 2)) else $error("interrupt fell alone");
    chk_dma_sticky: assert property ($fell(dma_req_o) |-> s_axi_bvalid_o
        || $past(s_axi_bvalid_o) || $past(dma_ack_i) || $past(dma_ack_i, 2))
        else $error("dma request fell alone");
endmodule
bind cts_top cts_top_asserts i_cts_top_asserts (.clk_i, .rst_n_i, .s_axi_awready_o,
    .s_axi_wready_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_arvalid_i, .s_axi_arready_o,
    .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .dma_req_o,
    .dma_ack_i, .irq_o);

// >>> cts_electrode_model.sv
// electrode front end model: a held count and an out-of-range level
`timescale 1ns/1ps
module cts_electrode_model (
    // clock
    input wire logic clk_i,
    // stimulus from the bench
    input wire logic [15:0] level_i,
    input wire logic touched_i,
    // pins toward the block
    output logic [15:0] sense_count_o,
    output logic out_of_range_o
);
    // outputs lag one cycle, like a slow analog front end settling
    always_ff @(posedge clk_i) begin
        sense_count_o <= level_i;
        out_of_range_o <= touched_i;
    end
endmodule

// >>> testbench.sv
// self-checking bench for the touch scan status block
`timescale 1ns/1ps
`include "cts_consts.svh"
module testbench;
    import cts_pkg::*;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [11:0] aw_a = 12'h0, ar_a = 12'h0;
    logic awv = 0, wv = 0, br = 0, arv = 0, rr = 0, ack = 0, touch = 0;
    cts_word_t wd = 32'h0, rd_d;
    logic [1:0] b_r, r_r;
    logic awr, wr_r, bv, arr, rv, dreq, irq, oor;
    logic [15:0] level = 16'h0, sense;
    logic [33:0] exp_r[$];
    logic [1:0] exp_b[$];
    int num_errors = 0, checks_done = 0, cyc = 0;
    cts_top i_cts_top (.clk_i(clk_i), .rst_n_i(rst_n_i), .s_axi_awaddr_i(aw_a),
        .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd),
        .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wv), .s_axi_wready_o(wr_r),
        .s_axi_bresp_o(b_r), .s_axi_bvalid_o(bv), .s_axi_bready_i(br),
        .s_axi_araddr_i(ar_a), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
        .s_axi_rdata_o(rd_d), .s_axi_rresp_o(r_r), .s_axi_rvalid_o(rv), .s_axi_rready_i(rr),
        .sense_count_i(sense), .out_of_range_i(oor), .dma_req_o(dreq), .dma_ack_i(ack),
        .irq_o(irq));
    cts_electrode_model i_cts_electrode_model (.clk_i(clk_i), .level_i(level),
        .touched_i(touch), .sense_count_o(sense), .out_of_range_o(oor));
    initial forever #12.5 clk_i = ~clk_i;
    task automatic fail(input string m);
        num_errors++;
        $display("BAD %0t %s", $time, m);
    endtask
    task automatic cmp_r(input logic [33:0] g, input logic [33:0] e);
        checks_done++;
        if (g !== e) fail("read response mismatch");
    endtask
    task automatic cmp_b(input logic [1:0] g, input logic [1:0] e);
        checks_done++;
        if (g !== e) fail("write response mismatch");
    endtask
    task automatic cmp_bit(input logic g, input logic e);
        checks_done++;
        if (g !== e) fail("output level mismatch");
    endtask
    task automatic wrap_up;
        if (num_errors == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // ready for the response is raised only once it is seen, to exercise holding
    task automatic wr(input logic [11:0] a, input cts_word_t d, input logic [1:0] r);
        exp_b.push_back(r);
        @(posedge clk_i);
        aw_a <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        do begin
            @(posedge clk_i);
            if (awv && awr) awv <= 1'b0;
            if (wv && wr_r) wv <= 1'b0;
            if (bv && !br) br <= 1'b1;
        end while (!(bv === 1'b1 && br) && cyc < 20000);
        br <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input cts_word_t d, input logic [1:0] r);
        exp_r.push_back({r, d});
        @(posedge clk_i);
        ar_a <= a;
        arv <= 1'b1;
        do begin
            @(posedge clk_i);
            if (arv && arr) arv <= 1'b0;
            if (rv && !rr) rr <= 1'b1;
        end while (!(rv === 1'b1 && rr) && cyc < 20000);
        rr <= 1'b0;
    endtask
    // bounded wait for the interrupt or the dma request
    task automatic wt(input bit on_dma);
        repeat (80) begin
            @(posedge clk_i);
            if ((on_dma ? dreq : irq) === 1'b1) break;
        end
    endtask
    task automatic pulse_ack;
        @(posedge clk_i);
        ack <= 1'b1;
        @(posedge clk_i);
        ack <= 1'b0;
    endtask
    // responses are matched to the oldest note in issue order
    always @(posedge clk_i) begin
        if (rv && rr) cmp_r({r_r, rd_d}, exp_r.pop_front());
        if (bv && br) cmp_b(b_r, exp_b.pop_front());
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail("timeout");
            wrap_up();
        end
    end
    initial begin
        void'($urandom(11));
        repeat (4) @(posedge clk_i);
        rst_n_i <= 1'b1;
        level <= 16'($urandom);
        rd(`CTS_OFF_CTRL, 32'h0, `CTS_AXI_OKAY);
        rd(`CTS_OFF_IRQ_EN, 32'h0, `CTS_AXI_OKAY);
        rd(`CTS_OFF_STATUS, 32'h0, `CTS_AXI_OKAY);
        rd(12'h010, 32'h0, `CTS_AXI_SLVERR);
        wr(12'h010, 32'h1, `CTS_AXI_SLVERR);
        wr(`CTS_OFF_IRQ_EN, 32'h1, `CTS_AXI_OKAY);
        wr(`CTS_OFF_CTRL, 32'h3, `CTS_AXI_OKAY);
        wt(0);
        cmp_bit(irq, 1'b1);
        rd(`CTS_OFF_STATUS, 32'h1, `CTS_AXI_OKAY);
        rd(`CTS_OFF_COUNT, {16'h0, level}, `CTS_AXI_OKAY);
        // a touch while the uncleared flag stalls scanning must not raise the range flag
        touch <= 1'b1;
        repeat (60) @(posedge clk_i);
        cmp_bit(irq, 1'b1);
        wr(`CTS_OFF_STATUS, 32'h0, `CTS_AXI_OKAY);
        rd(`CTS_OFF_STATUS, 32'h1, `CTS_AXI_OKAY);
        wr(`CTS_OFF_IRQ_EN, 32'h0, `CTS_AXI_OKAY);
        cmp_bit(irq, 1'b0);
        wr(`CTS_OFF_IRQ_EN, 32'h1, `CTS_AXI_OKAY);
        touch <= 1'b1;
        wr(`CTS_OFF_STATUS, 32'h1, `CTS_AXI_OKAY);
        cmp_bit(irq, 1'b0);
        wt(0);
        cmp_bit(irq, 1'b1);
        rd(`CTS_OFF_STATUS, 32'h3, `CTS_AXI_OKAY);
        touch <= 1'b0;
        wr(`CTS_OFF_STATUS, 32'h3, `CTS_AXI_OKAY);
        rd(`CTS_OFF_STATUS, 32'h0, `CTS_AXI_OKAY);
        wr(`CTS_OFF_IRQ_EN, 32'h0, `CTS_AXI_OKAY);
        wr(`CTS_OFF_CTRL, 32'h7, `CTS_AXI_OKAY);
        wt(1);
        cmp_bit(dreq, 1'b1);
        rd(`CTS_OFF_STATUS, 32'h5, `CTS_AXI_OKAY);
        pulse_ack();
        repeat (3) @(posedge clk_i);
        cmp_bit(dreq, 1'b0);
        wt(1);
        cmp_bit(dreq, 1'b1);
        // low power: dma must neither request nor clear the flag
        wr(`CTS_OFF_CTRL, 32'hf, `CTS_AXI_OKAY);
        wr(`CTS_OFF_IRQ_EN, 32'h1, `CTS_AXI_OKAY);
        cmp_bit(dreq, 1'b0);
        pulse_ack();
        rd(`CTS_OFF_STATUS, 32'h1, `CTS_AXI_OKAY);
        cmp_bit(irq, 1'b1);
        wr(`CTS_OFF_STATUS, 32'h1, `CTS_AXI_OKAY);
        cmp_bit(irq, 1'b0);
        wrap_up();
    end
endmodule
